/* File: src/port_pin_mode_and_data_regs.sv */
// How it works
// - five-bit function select; zero means plain gpio
// - codes 1-10 serial, serial-peripheral, i2c signals
// - codes 11-14 infrared receive and transmit
// - analog only port0 pins 3-0 (here accepted on every pad); diag port0
// - codes 19-22 active-low flow control signals
// - duplicated inputs: lowest pin, port0 first
// - pull field: none, up, down, output
// - analog function ignores pull field
// - reset: pull down, gpio function
// - data write sets outputs; read returns pins
// - set register: ones set bits, reads zero
// - clear register: ones clear bits, reads zero
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module port_pin_mode_and_data_regs
  import gpio_port_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads: 0 port0 pin6, 1 port0 pin7, 2 port1 pin0, 3 port1 pin1
  input wire logic [NPAD-1:0] pad_in,
  output logic [NPAD-1:0] pad_out,
  output logic [NPAD-1:0] pad_oe_n,
  output logic [NPAD-1:0] pad_pull_up,
  output logic [NPAD-1:0] pad_pull_down,
  // rest of port 1 and port 0 output data
  input wire logic [PORT1_W-3:0] port1_rest_in,
  input wire logic [1:0] port0_gpio_out,
  output logic [PORT1_W-1:0] port1_out,
  // peripheral outputs towards the pads
  input wire logic serial1_tx,
  input wire logic serial2_tx,
  input wire logic sp_data_out,
  input wire logic sp_clk,
  input wire logic sp_enable,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  input wire logic serial1_infrared_tx,
  input wire logic serial2_infrared_tx,
  input wire logic [4:0] modulator_out,
  input wire logic radio_diagnostic_out,
  input wire logic serial1_request_to_send_n,
  input wire logic serial2_request_to_send_n,
  // peripheral inputs from the pads
  output logic serial1_rx,
  output logic serial2_rx,
  output logic serial_periph_data_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic serial1_infrared_rx,
  output logic serial2_infrared_rx,
  output logic serial1_clear_to_send_n,
  output logic serial2_clear_to_send_n
);

  // mode registers and port 1 output register
  logic [NPAD-1:0][4:0] func_q;
  logic [NPAD-1:0][1:0] pull_q;
  logic [PORT1_W-1:0] port1_out_q;

  // bus decode
  logic wr;
  logic hit_mode;
  logic hit_data;
  logic hit_set;
  logic hit_clr;
  logic hit_any;
  logic [1:0] mode_i;
  logic [31:0] rd_val;
  logic [31:0] prdata_q;

  // pad side
  logic [SYNC_W-1:0] lev;
  logic [PORT1_W-1:0] port1_lev;
  logic [NPAD-1:0] gpio_vec;
  logic [31:0] drv;
  logic [31:0] drv_en;
  logic [NPAD-1:0] cell_out;
  logic [NPAD-1:0] cell_oe_n;
  logic [NPAD-1:0] cell_pu;
  logic [NPAD-1:0] cell_pd;

  // first pad selecting the code wins; scanned from the top so index 0 lands last
  function automatic logic pick_in(input pin_func_t code,
                                   input logic [NPAD-1:0][4:0] sel,
                                   input logic [NPAD-1:0] lv,
                                   input logic idle);
    logic r;
    r = idle;
    for (int i = NPAD - 1; i >= 0; i--) begin
      if (sel[i] == code) begin
        r = lv[i];
      end
    end
    return r;
  endfunction

  // zero-wait slave: a write lands at the access edge
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign hit_any = hit_mode || hit_data || hit_set || hit_clr;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;

  // address decode
  always_comb begin
    hit_mode = 1'b0;
    hit_data = 1'b0;
    hit_set = 1'b0;
    hit_clr = 1'b0;
    mode_i = 2'd0;
    if (paddr == ADR_PORT0_PIN6_MODE) begin
      hit_mode = 1'b1;
      mode_i = 2'd0;
    end else if (paddr == ADR_PORT0_PIN7_MODE) begin
      hit_mode = 1'b1;
      mode_i = 2'd1;
    end else if (paddr == ADR_PORT1_PIN0_MODE) begin
      hit_mode = 1'b1;
      mode_i = 2'd2;
    end else if (paddr == ADR_PORT1_PIN1_MODE) begin
      hit_mode = 1'b1;
      mode_i = 2'd3;
    end else if (paddr == ADR_PORT1_DATA) begin
      hit_data = 1'b1;
    end else if (paddr == ADR_PORT1_BIT_SET) begin
      hit_set = 1'b1;
    end else if (paddr == ADR_PORT1_BIT_CLEAR) begin
      hit_clr = 1'b1;
    end
  end

  // read value; set, clear, unmapped and reserved bits all read zero
  always_comb begin
    rd_val = '0;
    if (hit_mode) begin
      rd_val[PULL_MSB:PULL_LSB] = pull_q[mode_i];
      rd_val[FUNC_MSB:FUNC_LSB] = func_q[mode_i];
    end else if (hit_data) begin
      rd_val[DATA_MSB:DATA_LSB] = port1_lev;
    end
  end

  // read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_val;
    end
  end

  // mode registers; only the two documented fields take write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= {NPAD{FUNC_RST}};
      pull_q <= {NPAD{PULL_RST}};
    end else if (wr && hit_mode) begin
      func_q[mode_i] <= pwdata[FUNC_MSB:FUNC_LSB];
      pull_q[mode_i] <= pwdata[PULL_MSB:PULL_LSB];
    end
  end

  // port 1 output register with write-one set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_out_q <= PORT1_RST;
    end else if (wr && hit_data) begin
      port1_out_q <= pwdata[DATA_MSB:DATA_LSB];
    end else if (wr && hit_set) begin
      port1_out_q <= port1_out_q | pwdata[DATA_MSB:DATA_LSB];
    end else if (wr && hit_clr) begin
      port1_out_q <= port1_out_q & ~pwdata[DATA_MSB:DATA_LSB];
    end
  end

  assign port1_out = port1_out_q;

  // pins are asynchronous to pclk, so all ten levels pass the filter
  input_sync #(
    .W(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({port1_rest_in, pad_in}),
    .dout(lev)
  );

  // the data register reads the pins themselves, not port1_out_q
  assign port1_lev = {lev[SYNC_W-1:NPAD], lev[3:2]};
  assign gpio_vec = {port1_out_q[1:0], port0_gpio_out};

  // driver table indexed by function code; input codes stay disabled
  always_comb begin
    drv = '0;
    drv_en = '0;
    drv[fn_serial1_tx] = serial1_tx;
    drv_en[fn_serial1_tx] = 1'b1;
    drv[fn_serial2_tx] = serial2_tx;
    drv_en[fn_serial2_tx] = 1'b1;
    drv[fn_sp_dout] = sp_data_out;
    drv_en[fn_sp_dout] = 1'b1;
    drv[fn_sp_clk] = sp_clk;
    drv_en[fn_sp_clk] = 1'b1;
    drv[fn_sp_en] = sp_enable;
    drv_en[fn_sp_en] = 1'b1;
    // i2c lines are open drain: pulled low or released
    drv_en[fn_i2c_scl] = i2c_scl_low;
    drv_en[fn_i2c_sda] = i2c_sda_low;
    drv[fn_ir1_tx] = serial1_infrared_tx;
    drv_en[fn_ir1_tx] = 1'b1;
    drv[fn_ir2_tx] = serial2_infrared_tx;
    drv_en[fn_ir2_tx] = 1'b1;
    drv[fn_mod0] = modulator_out[0];
    drv[fn_mod1] = modulator_out[1];
    drv[fn_mod2] = modulator_out[2];
    drv[fn_mod3] = modulator_out[3];
    drv[fn_mod4] = modulator_out[4];
    drv_en[fn_mod0] = 1'b1;
    drv_en[fn_mod1] = 1'b1;
    drv_en[fn_mod2] = 1'b1;
    drv_en[fn_mod3] = 1'b1;
    drv_en[fn_mod4] = 1'b1;
    drv[fn_diag] = radio_diagnostic_out;
    drv_en[fn_diag] = 1'b1;
    drv[fn_rts1_n] = serial1_request_to_send_n;
    drv_en[fn_rts1_n] = 1'b1;
    drv[fn_rts2_n] = serial2_request_to_send_n;
    drv_en[fn_rts2_n] = 1'b1;
  end

  // one cell per pad; the diagnostic route exists on port 0 only
  for (genvar g = 0; g < NPAD; g++) begin : g_pad
    pin_mux_cell #(
      .DIAG_OK(g < 2)
    ) u_cell (
      .func(func_q[g]),
      .pull(pull_q[g]),
      .gpio_out(gpio_vec[g]),
      .drv(drv),
      .drv_en(drv_en),
      .pad_out(cell_out[g]),
      .pad_oe_n(cell_oe_n[g]),
      .pull_up(cell_pu[g]),
      .pull_down(cell_pd[g])
    );
  end

  // pad controls leave flops; costs one cycle after a mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= {NPAD{PAD_OUT_RST}};
      pad_oe_n <= {NPAD{PAD_OE_N_RST}};
      pad_pull_up <= {NPAD{PAD_PU_RST}};
      pad_pull_down <= {NPAD{PAD_PD_RST}};
    end else begin
      pad_out <= cell_out;
      pad_oe_n <= cell_oe_n;
      pad_pull_up <= cell_pu;
      pad_pull_down <= cell_pd;
    end
  end

  // peripheral inputs; unselected ones rest at their idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial1_rx <= IN_IDLE_HIGH;
      serial2_rx <= IN_IDLE_HIGH;
      serial_periph_data_in <= IN_IDLE_LOW;
      i2c_scl_in <= IN_IDLE_HIGH;
      i2c_sda_in <= IN_IDLE_HIGH;
      serial1_infrared_rx <= IN_IDLE_LOW;
      serial2_infrared_rx <= IN_IDLE_LOW;
      serial1_clear_to_send_n <= IN_IDLE_HIGH;
      serial2_clear_to_send_n <= IN_IDLE_HIGH;
    end else begin
      serial1_rx <= pick_in(fn_serial1_rx, func_q, lev[3:0], IN_IDLE_HIGH);
      serial2_rx <= pick_in(fn_serial2_rx, func_q, lev[3:0], IN_IDLE_HIGH);
      serial_periph_data_in <= pick_in(fn_sp_din, func_q, lev[3:0], IN_IDLE_LOW);
      i2c_scl_in <= pick_in(fn_i2c_scl, func_q, lev[3:0], IN_IDLE_HIGH);
      i2c_sda_in <= pick_in(fn_i2c_sda, func_q, lev[3:0], IN_IDLE_HIGH);
      serial1_infrared_rx <= pick_in(fn_ir1_rx, func_q, lev[3:0], IN_IDLE_LOW);
      serial2_infrared_rx <= pick_in(fn_ir2_rx, func_q, lev[3:0], IN_IDLE_LOW);
      serial1_clear_to_send_n <= pick_in(fn_cts1_n, func_q, lev[3:0], IN_IDLE_HIGH);
      serial2_clear_to_send_n <= pick_in(fn_cts2_n, func_q, lev[3:0], IN_IDLE_HIGH);
    end
  end

  // checks on the register file and the pad routing
  property p_data_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_data) |=> (port1_out == $past(pwdata[7:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write not stored");

  property p_set_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_set) |=> (port1_out == ($past(port1_out) | $past(pwdata[7:0])));
  endproperty
  a_set_write: assert property (p_set_write) else $error("set write wrong");

  property p_clear_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_clr) |=> (port1_out == ($past(port1_out) & ~$past(pwdata[7:0])));
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear write wrong");

  property p_setclr_read_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && (hit_set || hit_clr)) |=> (prdata == 32'h0000_0000);
  endproperty
  a_setclr_read_zero: assert property (p_setclr_read_zero) else $error("set/clear read not 0");

  property p_data_read_pins;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_data) |=> (prdata[7:0] == $past(port1_lev));
  endproperty
  a_data_read_pins: assert property (p_data_read_pins) else $error("data read not pins");

  property p_mode_reserved;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_mode) |=> (prdata[31:10] == '0) && (prdata[7:5] == '0);
  endproperty
  a_mode_reserved: assert property (p_mode_reserved) else $error("reserved bits not 0");

  property p_lowest_pin_wins;
    @(posedge pclk) disable iff (!presetn)
    (func_q[0] == fn_serial1_rx && func_q[2] == fn_serial1_rx) |=> (serial1_rx == $past(lev[0]));
  endproperty
  a_lowest_pin_wins: assert property (p_lowest_pin_wins) else $error("input priority wrong");

  property p_gpio_pull_down;
    @(posedge pclk) disable iff (!presetn)
    (func_q[2] == fn_gpio && pull_q[2] == PULL_DOWN) |=>
      (pad_pull_down[2] && !pad_pull_up[2] && pad_oe_n[2]);
  endproperty
  a_gpio_pull_down: assert property (p_gpio_pull_down) else $error("pull-down not applied");

  property p_analog_no_pull;
    @(posedge pclk) disable iff (!presetn)
    (func_q[1] == fn_analog) |=> (!pad_pull_up[1] && !pad_pull_down[1] && pad_oe_n[1]);
  endproperty
  a_analog_no_pull: assert property (p_analog_no_pull) else $error("analog pad not released");

  property p_rts_drive;
    @(posedge pclk) disable iff (!presetn)
    (func_q[1] == fn_rts2_n) |=> (!pad_oe_n[1] && pad_out[1] == $past(serial2_request_to_send_n));
  endproperty
  a_rts_drive: assert property (p_rts_drive) else $error("flow control not driven");

  property p_diag_port1_off;
    @(posedge pclk) disable iff (!presetn)
    (func_q[3] == fn_diag) |=> pad_oe_n[3];
  endproperty
  a_diag_port1_off: assert property (p_diag_port1_off) else $error("diag driven on port 1");

endmodule // port_pin_mode_and_data_regs

`default_nettype wire

/* File: shared/gpio_port_pkg.sv */
package gpio_port_pkg;

  // bus and port geometry
  localparam int ADDR_W = 12;
  localparam int PORT1_W = 8;
  localparam int NPAD = 4;
  localparam int SYNC_W = 10;

  // printed register addresses; each one is the block base plus the register's word index
  localparam logic [31:0] REG_BASE = 32'h5000_3000;
  localparam logic [31:0] OFS_PORT0_PIN6_MODE = 32'h5000_3012;
  localparam logic [31:0] OFS_PORT0_PIN7_MODE = 32'h5000_3014;
  localparam logic [31:0] OFS_PORT1_DATA = 32'h5000_3020;
  localparam logic [31:0] OFS_PORT1_BIT_SET = 32'h5000_3022;
  localparam logic [31:0] OFS_PORT1_BIT_CLEAR = 32'h5000_3024;
  localparam logic [31:0] OFS_PORT1_PIN0_MODE = 32'h5000_3026;
  localparam logic [31:0] OFS_PORT1_PIN1_MODE = 32'h5000_3028;

  // word index relative to the block base, times four, is the bus byte address
  function automatic logic [ADDR_W-1:0] word_to_byte(input logic [31:0] ofs);
    logic [31:0] idx;
    idx = ofs - REG_BASE;
    return {idx[ADDR_W-3:0], 2'b00};
  endfunction

  localparam logic [ADDR_W-1:0] ADR_PORT0_PIN6_MODE = word_to_byte(OFS_PORT0_PIN6_MODE);
  localparam logic [ADDR_W-1:0] ADR_PORT0_PIN7_MODE = word_to_byte(OFS_PORT0_PIN7_MODE);
  localparam logic [ADDR_W-1:0] ADR_PORT1_DATA = word_to_byte(OFS_PORT1_DATA);
  localparam logic [ADDR_W-1:0] ADR_PORT1_BIT_SET = word_to_byte(OFS_PORT1_BIT_SET);
  localparam logic [ADDR_W-1:0] ADR_PORT1_BIT_CLEAR = word_to_byte(OFS_PORT1_BIT_CLEAR);
  localparam logic [ADDR_W-1:0] ADR_PORT1_PIN0_MODE = word_to_byte(OFS_PORT1_PIN0_MODE);
  localparam logic [ADDR_W-1:0] ADR_PORT1_PIN1_MODE = word_to_byte(OFS_PORT1_PIN1_MODE);

  // field positions
  localparam int FUNC_LSB = 0;
  localparam int FUNC_MSB = 4;
  localparam int PULL_LSB = 8;
  localparam int PULL_MSB = 9;
  localparam int DATA_LSB = 0;
  localparam int DATA_MSB = 7;

  // pull configuration codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] PULL_OUT = 2'h3;

  // values after reset
  localparam logic [4:0] FUNC_RST = 5'h00;
  localparam logic [1:0] PULL_RST = 2'h2;
  localparam logic [7:0] PORT1_RST = 8'h00;
  localparam logic PAD_OUT_RST = 1'b0;
  localparam logic PAD_OE_N_RST = 1'b1;
  localparam logic PAD_PU_RST = 1'b0;
  localparam logic PAD_PD_RST = 1'b1;
  localparam logic IN_IDLE_HIGH = 1'b1;
  localparam logic IN_IDLE_LOW = 1'b0;

  // pin function select codes
  typedef enum logic [4:0] {
    fn_gpio = 5'b00000, fn_serial1_rx = 5'b00001, fn_serial1_tx = 5'b00010,
    fn_serial2_rx = 5'b00011, fn_serial2_tx = 5'b00100, fn_sp_din = 5'b00101,
    fn_sp_dout = 5'b00110, fn_sp_clk = 5'b00111, fn_sp_en = 5'b01000,
    fn_i2c_scl = 5'b01001, fn_i2c_sda = 5'b01010, fn_ir1_rx = 5'b01011,
    fn_ir1_tx = 5'b01100, fn_ir2_rx = 5'b01101, fn_ir2_tx = 5'b01110,
    fn_analog = 5'b01111, fn_mod0 = 5'b10000, fn_mod1 = 5'b10001,
    fn_diag = 5'b10010, fn_cts1_n = 5'b10011, fn_rts1_n = 5'b10100,
    fn_cts2_n = 5'b10101, fn_rts2_n = 5'b10110, fn_mod2 = 5'b10111,
    fn_mod3 = 5'b11000, fn_mod4 = 5'b11001
  } pin_func_t;

endpackage

/* File: src/input_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module input_sync
  import gpio_port_pkg::*;
#(
  parameter int W = SYNC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw levels and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // three stages; the first is seen only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only once stages two and three agree, so a glitch caught at one edge only never counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // input_sync

`default_nettype wire

/* File: src/pin_mux_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_mux_cell
  import gpio_port_pkg::*;
#(
  parameter bit DIAG_OK = 1'b0
) (
  // mode register fields
  input wire logic [4:0] func,
  input wire logic [1:0] pull,
  // sources
  input wire logic gpio_out,
  input wire logic [31:0] drv,
  input wire logic [31:0] drv_en,
  // pad controls
  output logic pad_out,
  output logic pad_oe_n,
  output logic pull_up,
  output logic pull_down
);

  // one pad: pick the driver, else leave an input with the chosen resistor, or with none for analog
  always_comb begin
    pad_out = 1'b0;
    pad_oe_n = 1'b1;
    pull_up = 1'b0;
    pull_down = 1'b0;
    case (pin_func_t'(func))
      fn_gpio: begin
        if (pull == PULL_OUT) begin
          pad_out = gpio_out;
          pad_oe_n = 1'b0;
        end else begin
          pull_up = (pull == PULL_UP);
          pull_down = (pull == PULL_DOWN);
        end
      end
      fn_analog: begin
        // analog use floats the pad and ignores the pull field
        pad_oe_n = 1'b1;
      end
      default: begin
        if (drv_en[func] && ((func != fn_diag) || DIAG_OK)) begin
          pad_out = drv[func];
          pad_oe_n = 1'b0;
        end else begin
          pull_up = (pull == PULL_UP);
          pull_down = (pull == PULL_DOWN);
        end
      end
    endcase
  end

endmodule // pin_mux_cell

`default_nettype wire

/* File: sim/port_pin_mode_and_data_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module port_pin_mode_and_data_regs_tb_top
  import gpio_port_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, src, rd;
  logic [NPAD-1:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down;
  logic [5:0] rest_in;
  logic [1:0] gpio0;
  logic [7:0] port1_out;
  logic [8:0] ins;
  int bad_count, n_tests;
  logic [ADDR_W-1:0] mads [4] = '{ADR_PORT0_PIN6_MODE, ADR_PORT0_PIN7_MODE,
                                  ADR_PORT1_PIN0_MODE, ADR_PORT1_PIN1_MODE};

  // free running bus clock, 10 ns period
  always #5 pclk = ~pclk;

  port_pin_mode_and_data_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .port1_rest_in(rest_in), .port0_gpio_out(gpio0),
    .port1_out(port1_out), .serial1_tx(src[2]), .serial2_tx(src[4]),
    .sp_data_out(src[6]), .sp_clk(src[7]), .sp_enable(src[8]),
    .i2c_scl_low(src[9]), .i2c_sda_low(src[10]),
    .serial1_infrared_tx(src[12]), .serial2_infrared_tx(src[14]),
    .modulator_out({src[25], src[24], src[23], src[17], src[16]}),
    .radio_diagnostic_out(src[18]), .serial1_request_to_send_n(src[20]),
    .serial2_request_to_send_n(src[22]), .serial1_rx(ins[0]), .serial2_rx(ins[1]),
    .serial_periph_data_in(ins[2]), .i2c_scl_in(ins[3]), .i2c_sda_in(ins[4]),
    .serial1_infrared_rx(ins[5]), .serial2_infrared_rx(ins[6]),
    .serial1_clear_to_send_n(ins[7]), .serial2_clear_to_send_n(ins[8])
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      bad_count++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      test_done();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // let registered pad controls and the input synchroniser settle
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  function automatic logic [31:0] mode(input logic [1:0] p, input logic [4:0] f);
    return {22'h0, p, 3'h0, f};
  endfunction

  // pad control triple of one pad: oe_n, pull up, pull down
  function automatic logic [31:0] ctl(input int k);
    return {29'h0, pad_oe_n[k], pad_pull_up[k], pad_pull_down[k]};
  endfunction

  task automatic t_reset();
    for (int k = 0; k < 4; k++) rdc("mode reset", mads[k], 32'h0000_0200);
    rdc("data reset", ADR_PORT1_DATA, 32'h0);
    chk("pad ctl reset", 32'h5, ctl(2));
    chk("port1 out reset", 32'h0, {24'h0, port1_out});
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int k = 0; k < 4; k++) begin
      wr(mads[k], 32'hffff_ffff);
      rdc("mode fields", mads[k], 32'h0000_031f);
      wr(mads[k], mode(PULL_NONE, 5'h00));
    end
    wr(ADR_PORT1_DATA, 32'hffff_ffa5);
    settle(1);
    chk("data write", 32'ha5, {24'h0, port1_out});
    wr(ADR_PORT1_BIT_SET, 32'h0000_ff0a);
    settle(1);
    chk("bit set", 32'haf, {24'h0, port1_out});
    wr(ADR_PORT1_BIT_CLEAR, 32'h0000_ff81);
    settle(1);
    chk("bit clear", 32'h2e, {24'h0, port1_out});
    rdc("set reads", ADR_PORT1_BIT_SET, 32'h0);
    rdc("clear reads", ADR_PORT1_BIT_CLEAR, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped read", 32'h1, {rd[30:0], err});
    $display("test registers done");
  endtask

  task automatic t_pull();
    wr(ADR_PORT1_DATA, 32'h0000_0001);
    gpio0 <= 2'b01;
    wr(ADR_PORT0_PIN6_MODE, mode(PULL_OUT, 5'h00));
    settle(2);
    chk("port0 gpio drive", 32'h1, {31'h0, pad_out[0]});
    for (int p = 0; p < 4; p++) begin
      wr(ADR_PORT1_PIN0_MODE, mode(p[1:0], 5'h00));
      settle(2);
      chk("pull ctl", {29'h0, p != 3, p == 1, p == 2}, ctl(2));
    end
    chk("port1 gpio drive", 32'h1, {31'h0, pad_out[2]});
    $display("test pull done");
  endtask

  // only the selected source is high, so a wrong route shows as a low pad, except for i2c codes 9 and 10, which expect a low pad
  task automatic t_out();
    int codes [17] = '{2, 4, 6, 7, 8, 9, 10, 12, 14, 16, 17, 18, 20, 22, 23, 24, 25};
    foreach (codes[k]) begin
      src <= 32'h1 << codes[k];
      wr(ADR_PORT0_PIN7_MODE, mode(PULL_NONE, codes[k][4:0]));
      settle(2);
      chk("out route", {30'h0, 1'b0, codes[k] != 9 && codes[k] != 10},
          {30'h0, pad_oe_n[1], pad_out[1]});
    end
    src <= 32'h0;
    $display("test outputs done");
  endtask

  task automatic t_in();
    int codes [9] = '{1, 3, 5, 9, 10, 11, 13, 19, 21};
    logic idle;
    foreach (codes[k]) begin
      idle = !(codes[k] == 5 || codes[k] == 11 || codes[k] == 13);
      wr(ADR_PORT1_PIN1_MODE, mode(PULL_NONE, codes[k][4:0]));
      pad_in[3] <= ~idle;
      settle(8);
      chk("in route", {31'h0, ~idle}, {31'h0, ins[k]});
      wr(ADR_PORT1_PIN1_MODE, mode(PULL_NONE, 5'h00));
      settle(3);
      chk("in idle", {31'h0, idle}, {31'h0, ins[k]});
    end
    pad_in[3] <= 1'b0;
    $display("test inputs done");
  endtask

  task automatic t_prio();
    wr(ADR_PORT0_PIN6_MODE, mode(PULL_NONE, 5'h01));
    wr(ADR_PORT1_PIN0_MODE, mode(PULL_NONE, 5'h01));
    pad_in[0] <= 1'b0;
    pad_in[2] <= 1'b1;
    rest_in <= 6'h2a;
    settle(8);
    chk("port0 wins", 32'h0, {31'h0, ins[0]});
    rdc("pin levels", ADR_PORT1_DATA, 32'ha9);
    wr(ADR_PORT0_PIN6_MODE, mode(PULL_NONE, 5'h00));
    // swap the levels so neither the idle level nor pad 0 can pass for pad 2
    pad_in[0] <= 1'b1;
    pad_in[2] <= 1'b0;
    settle(8);
    chk("port1 takes over", 32'h0, {31'h0, ins[0]});
    $display("test priority done");
  endtask

  task automatic t_analog();
    wr(ADR_PORT0_PIN7_MODE, mode(PULL_UP, 5'h0f));
    settle(2);
    chk("analog floats", 32'h4, ctl(1));
    rdc("analog readback", ADR_PORT0_PIN7_MODE, 32'h0000_010f);
    wr(ADR_PORT1_PIN1_MODE, mode(PULL_OUT, 5'h12));
    settle(2);
    chk("diag not on port1", 32'h1, {31'h0, pad_oe_n[3]});
    $display("test analog done");
  endtask

  // every input has a value at time zero; reset spans two edges
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pad_in, rest_in, gpio0, src} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_pull();
    t_out();
    t_in();
    t_prio();
    t_analog();
    test_done();
  end
endmodule // port_pin_mode_and_data_regs_tb_top

`default_nettype wire
